// ==== core/dsp_elem_pkg.sv ====
// shared constants and types for the multiply element
package dsp_elem_pkg;
  localparam int ACC_W = 52;
  localparam int OP_W = 18;
  localparam int SHIFT_MAX_W = 18;
  localparam int LANES = 4;
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] ROUTE_OFS = 8'h04;
  localparam logic [7:0] RESLO_OFS = 8'h08;
  localparam logic [7:0] RESHI_OFS = 8'h0C;
  localparam logic [7:0] STAT_OFS = 8'h10;
  typedef enum logic [1:0] {
    MODE_MAC = 2'h0,
    MODE_ADDSUB = 2'h1,
    MODE_SUM = 2'h2
  } mode_e;
  typedef enum logic [1:0] {
    FMT_PAR = 2'h0,
    FMT_SHIFT = 2'h1,
    FMT_DYN = 2'h2
  } fmt_e;
  typedef struct packed {
    logic adv;
    logic out_en;
    logic [3:0] mpipe_en;
    logic as_in_en;
    logic sgn_pipe_en;
    logic sgn_in_en;
    logic in_en;
    fmt_e fmt_b;
    fmt_e fmt_a;
    mode_e mode;
  } cfg_s;
  typedef struct packed {
    logic [1:0] rst_out;
    logic [1:0] ce_out;
    logic [1:0] rst_pipe;
    logic [1:0] ce_pipe;
    logic [1:0] rst_in;
    logic [1:0] ce_in;
  } route_s;
  typedef struct packed {
    logic [1:0] addsub;
    logic load;
    logic sa;
    logic sb;
    logic srca;
    logic srcb;
  } ctrl_s;
  localparam cfg_s CFG_RESET = 16'h0000;
  localparam route_s ROUTE_RESET = 12'h000;
endpackage : dsp_elem_pkg

// ==== core/dsp_mac_addsub_element.sv ====
// multiply element: accumulate, two-product add/sub, four-product sum
// Behaviour
// - accumulator holds a 52-bit running sum
// - load control loads accumulator from the load-value port
// - load low adds product to held value, high loads instead
// - in accumulate mode the output register is always present and clocked
// - basic configuration: all registers share reset line 0; all but the output register with out_en clear outside accumulate mode use enable line 0
// - advanced configuration: each stage picks its own enable and reset line
// - operand format per element: parallel, shifted or dynamic
// - shifted format only below 18-bit operands; gives a shift chain
// - source select low picks parallel input, high picks shifted input
// - signedness low means unsigned, high means two's complement
// - operands from 2 to 72 bits by spanning elements
// - add/sub function combines two products by add or subtract
// - add/sub control low subtracts, high adds
// - sum function adds the two add/sub pair results
// - add/sub control has its own optional input register
// - signedness controls have optional input and pipeline registers
// - each multiplier has its own optional pipeline register
// - no observation point between multiplier and accumulator
`timescale 1ns/1ns
`default_nettype none
module dsp_mac_addsub_element #(
  parameter int W = dsp_elem_pkg::OP_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0][W-1:0] op_a,
  input wire logic [3:0][W-1:0] op_b,
  input wire logic [W-1:0] shift_a_in,
  input wire logic [W-1:0] shift_b_in,
  input wire dsp_elem_pkg::ctrl_s ctrl,
  input wire logic [dsp_elem_pkg::ACC_W-1:0] accum_load_value,
  input wire logic [3:0] ce_lines,
  input wire logic [3:0] rst_lines,
  output logic [dsp_elem_pkg::ACC_W-1:0] result,
  output logic [W-1:0] shift_a_out,
  output logic [W-1:0] shift_b_out
);
  localparam int AW = dsp_elem_pkg::ACC_W;
  localparam int PW = 2 * W + 2;
  localparam bit SHIFT_OK = (W < dsp_elem_pkg::SHIFT_MAX_W);

  dsp_elem_pkg::cfg_s cfg_reg;
  dsp_elem_pkg::route_s route_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic [3:0][W-1:0] a_sh_reg;
  logic [3:0][W-1:0] b_sh_reg;
  logic [3:0][W-1:0] a_in_reg;
  logic [3:0][W-1:0] b_in_reg;
  dsp_elem_pkg::ctrl_s ctrl_in_reg;
  logic [1:0] sgn_pipe_reg;
  logic [3:0][PW-1:0] prod_reg;
  logic [AW-1:0] result_reg;

  // stage enable and clear routing
  dsp_elem_pkg::route_s rt;
  assign rt = cfg_reg.adv ? route_reg : dsp_elem_pkg::ROUTE_RESET;
  wire en_in = clk_en & ce_lines[rt.ce_in];
  wire en_pipe = clk_en & ce_lines[rt.ce_pipe];
  wire en_out = clk_en & ce_lines[rt.ce_out];
  wire clr_in = rst_lines[rt.rst_in];
  wire clr_pipe = rst_lines[rt.rst_pipe];
  wire clr_out = rst_lines[rt.rst_out];

  // control input stage
  wire ctl_in_en = cfg_reg.in_en;
  wire [1:0] addsub_q = cfg_reg.as_in_en ? ctrl_in_reg.addsub : ctrl.addsub;
  wire sa_q = cfg_reg.sgn_in_en ? ctrl_in_reg.sa : ctrl.sa;
  wire sb_q = cfg_reg.sgn_in_en ? ctrl_in_reg.sb : ctrl.sb;
  wire load_q = ctl_in_en ? ctrl_in_reg.load : ctrl.load;
  wire srca_pin = ctl_in_en ? ctrl_in_reg.srca : ctrl.srca;
  wire srcb_pin = ctl_in_en ? ctrl_in_reg.srcb : ctrl.srcb;
  wire [1:0] sgn_p = cfg_reg.sgn_pipe_en ? sgn_pipe_reg : {sa_q, sb_q};

  // operand source resolution
  wire srca_eff = SHIFT_OK && ((cfg_reg.fmt_a == dsp_elem_pkg::FMT_SHIFT) ||
                  (cfg_reg.fmt_a == dsp_elem_pkg::FMT_DYN && srca_pin));
  wire srcb_eff = SHIFT_OK && ((cfg_reg.fmt_b == dsp_elem_pkg::FMT_SHIFT) ||
                  (cfg_reg.fmt_b == dsp_elem_pkg::FMT_DYN && srcb_pin));
  wire [3:0][W-1:0] a_chain = {a_sh_reg[2:0], shift_a_in};
  wire [3:0][W-1:0] b_chain = {b_sh_reg[2:0], shift_b_in};

  logic [3:0][PW-1:0] prod_c;
  logic [3:0][AW-1:0] ext_p;
  genvar i;
  generate
    for (i = 0; i < dsp_elem_pkg::LANES; i++)
    begin : g_lane
      wire [W-1:0] a_par = cfg_reg.in_en ? a_in_reg[i] : op_a[i];
      wire [W-1:0] b_par = cfg_reg.in_en ? b_in_reg[i] : op_b[i];
      wire [W-1:0] a_m = srca_eff ? a_sh_reg[i] : a_par;
      wire [W-1:0] b_m = srcb_eff ? b_sh_reg[i] : b_par;
      wire signed [W:0] a_x = {sa_q & a_m[W-1], a_m};
      wire signed [W:0] b_x = {sb_q & b_m[W-1], b_m};
      wire signed [PW-1:0] p_s = a_x * b_x;
      wire [PW-1:0] p_q = cfg_reg.mpipe_en[i] ? prod_reg[i] : prod_c[i];
      assign prod_c[i] = p_s;
      assign ext_p[i] = {{(AW - PW){p_q[PW-1]}}, p_q};
    end
  endgenerate

  // combining adders and accumulator; product reaches only the output register
  wire [AW-1:0] pair0 = addsub_q[0] ? ext_p[0] + ext_p[1] : ext_p[0] - ext_p[1];
  wire [AW-1:0] pair1 = addsub_q[1] ? ext_p[2] + ext_p[3] : ext_p[2] - ext_p[3];
  wire [AW-1:0] sum_all = pair0 + pair1;
  wire is_mac = (cfg_reg.mode == dsp_elem_pkg::MODE_MAC);
  wire [AW-1:0] acc_next = load_q ? accum_load_value : result_reg + ext_p[0];
  wire [AW-1:0] result_next = is_mac ? acc_next :
                  (cfg_reg.mode == dsp_elem_pkg::MODE_ADDSUB) ? pair0 : sum_all;
  wire out_tick = (is_mac || cfg_reg.out_en) ? en_out : clk_en;

  // input stage registers and shift chains
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_sh_reg <= '0;
      b_sh_reg <= '0;
      a_in_reg <= '0;
      b_in_reg <= '0;
      ctrl_in_reg <= '0;
    end else if (clr_in)
    begin
      a_sh_reg <= '0;
      b_sh_reg <= '0;
      a_in_reg <= '0;
      b_in_reg <= '0;
      ctrl_in_reg <= '0;
    end else if (en_in)
    begin
      a_sh_reg <= a_chain;
      b_sh_reg <= b_chain;
      a_in_reg <= op_a;
      b_in_reg <= op_b;
      ctrl_in_reg <= ctrl;
    end
  end

  // pipeline stage registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prod_reg <= '0;
      sgn_pipe_reg <= 2'h0;
    end else if (clr_pipe)
    begin
      prod_reg <= '0;
      sgn_pipe_reg <= 2'h0;
    end else if (en_pipe)
    begin
      prod_reg <= prod_c;
      sgn_pipe_reg <= {sa_q, sb_q};
    end
  end

  // output register, the accumulator state in accumulate mode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      result_reg <= '0;
    else if (clr_out)
      result_reg <= '0;
    else if (out_tick)
      result_reg <= result_next;
  end

  // bus slave, zero wait states
  wire take = hsel & hready & htrans[1];
  wire [31:0] rd_val = (haddr[7:0] == dsp_elem_pkg::CFG_OFS) ? {16'h0000, cfg_reg} :
    (haddr[7:0] == dsp_elem_pkg::ROUTE_OFS) ? {20'h00000, route_reg} :
    (haddr[7:0] == dsp_elem_pkg::RESLO_OFS) ? result_reg[31:0] :
    (haddr[7:0] == dsp_elem_pkg::RESHI_OFS) ? {12'h000, result_reg[AW-1:32]} :
    (haddr[7:0] == dsp_elem_pkg::STAT_OFS) ?
      {25'h0000000, sgn_p, srca_eff, srcb_eff, load_q, addsub_q} : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else
    begin
      hreadyout_reg <= 1'b1;
      wr_pend_reg <= take & hwrite;
      addr_reg <= haddr[7:0];
      if (take && !hwrite)
        hrdata_reg <= rd_val;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_reg <= dsp_elem_pkg::CFG_RESET;
      route_reg <= dsp_elem_pkg::ROUTE_RESET;
    end else if (wr_pend_reg)
    begin
      if (addr_reg == dsp_elem_pkg::CFG_OFS)
        cfg_reg <= hwdata[15:0];
      if (addr_reg == dsp_elem_pkg::ROUTE_OFS)
        route_reg <= hwdata[11:0];
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0;
  assign result = result_reg;
  assign shift_a_out = a_sh_reg[3];
  assign shift_b_out = b_sh_reg[3];

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire go_out = out_tick & !clr_out;
  // accumulator and output register
  a_acc_load: assert property (is_mac && go_out && load_q
    |=> result == $past(accum_load_value)) else $error("load not taken");
  a_acc_add: assert property (is_mac && go_out && !load_q
    |=> result == $past(result) + $past(ext_p[0])) else $error("bad accumulate");
  a_out_clear: assert property (clr_out |=> result == '0)
    else $error("output not cleared");
  a_acc_hold: assert property (is_mac && !en_out && !clr_out |=> $stable(result))
    else $error("accumulator moved");
  a_result_hold: assert property (!out_tick && !clr_out |=> $stable(result))
    else $error("output register moved");
  a_clk_freeze: assert property (!clk_en && !clr_out |=> $stable(result))
    else $error("output moved while frozen");
  // operand sources and input stage
  a_shift_narrow: assert property (!SHIFT_OK |-> !srca_eff && !srcb_eff)
    else $error("shift on wide operand");
  a_src_dynamic: assert property (SHIFT_OK && cfg_reg.fmt_a == dsp_elem_pkg::FMT_DYN
    |-> srca_eff == srca_pin) else $error("source select wrong");
  a_src_dyn_b: assert property (SHIFT_OK && cfg_reg.fmt_b == dsp_elem_pkg::FMT_DYN
    |-> srcb_eff == srcb_pin) else $error("source select b wrong");
  a_shift_chain: assert property (en_in && !clr_in
    |=> a_sh_reg[1] == $past(a_sh_reg[0])) else $error("chain stalled");
  a_chain_clear: assert property (clr_in |=> a_sh_reg == '0 && b_sh_reg == '0)
    else $error("chain not cleared");
  a_in_capture: assert property (en_in && !clr_in |=> a_in_reg == $past(op_a))
    else $error("operand not captured");
  a_in_hold: assert property (!en_in && !clr_in
    |=> $stable(a_in_reg) && $stable(ctrl_in_reg)) else $error("input stage moved");
  a_in_clear: assert property (clr_in |=> a_in_reg == '0 && ctrl_in_reg == '0)
    else $error("input stage not cleared");
  a_addsub_reg: assert property (en_in && !clr_in
    |=> ctrl_in_reg.addsub == $past(ctrl.addsub)) else $error("add/sub not registered");
  a_sign_reg: assert property (en_in && !clr_in |=> ctrl_in_reg.sa == $past(ctrl.sa))
    else $error("sign not registered");
  // pipeline stage
  a_sign_pipe: assert property (en_pipe && !clr_pipe
    |=> sgn_pipe_reg[1] == $past(sa_q)) else $error("sign pipe wrong");
  a_unsigned_prod: assert property (!sa_q && !sb_q |-> prod_c[0][PW-1:PW-2] == 2'h0)
    else $error("unsigned product sign-extended");
  a_pipe_load: assert property (en_pipe && !clr_pipe |=> prod_reg == $past(prod_c))
    else $error("product not piped");
  a_pipe_hold: assert property (!en_pipe && !clr_pipe |=> $stable(prod_reg))
    else $error("product pipe moved");
  a_pipe_clear: assert property (clr_pipe |=> prod_reg == '0 && sgn_pipe_reg == 2'h0)
    else $error("pipe not cleared");
  // combining adders
  a_addsub_add: assert property (cfg_reg.mode == dsp_elem_pkg::MODE_ADDSUB && go_out
    && addsub_q[0] |=> result == $past(ext_p[0]) + $past(ext_p[1]))
    else $error("add pair wrong");
  a_sub_pair: assert property (cfg_reg.mode == dsp_elem_pkg::MODE_ADDSUB && go_out
    && !addsub_q[0] |=> result == $past(ext_p[0]) - $past(ext_p[1]))
    else $error("subtract wrong");
  a_sum_total: assert property (cfg_reg.mode == dsp_elem_pkg::MODE_SUM && go_out
    |=> result == $past(pair0) + $past(pair1)) else $error("sum wrong");
  a_sum_sub: assert property (cfg_reg.mode == dsp_elem_pkg::MODE_SUM && go_out
    && !addsub_q[1] |=> result == $past(pair0) + $past(ext_p[2]) - $past(ext_p[3]))
    else $error("second pair subtract wrong");
  // enable and clear routing
  a_basic_route: assert property (!cfg_reg.adv
    |-> en_in == (clk_en & ce_lines[0]) && clr_out == rst_lines[0])
    else $error("basic routing wrong");
  a_adv_route: assert property (cfg_reg.adv
    |-> en_out == (clk_en & ce_lines[route_reg.ce_out]))
    else $error("advanced routing wrong");
  // main scenarios
  c_load_then_acc: cover property (is_mac && go_out && load_q ##1 go_out && !load_q);
  c_sum_mode: cover property (cfg_reg.mode == dsp_elem_pkg::MODE_SUM && go_out);
  c_shift_used: cover property (srca_eff && en_in);
  c_pipe_used: cover property (cfg_reg.mpipe_en[0] && en_pipe);
  c_adv_route: cover property (cfg_reg.adv && go_out);
endmodule : dsp_mac_addsub_element
`default_nettype wire

// ==== test/fabric_model.sv ====
// fabric-side model registering operands and controls toward the element
`timescale 1ns/1ns
`default_nettype none
module fabric_model #(
  parameter int W = 18
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0][W-1:0] a_next,
  input wire logic [3:0][W-1:0] b_next,
  input wire dsp_elem_pkg::ctrl_s ctrl_next,
  input wire logic [51:0] ld_next,
  input wire logic [3:0] ce_next,
  input wire logic [3:0] rst_next,
  input wire logic [W-1:0] sh_next,
  output logic [3:0][W-1:0] op_a,
  output logic [3:0][W-1:0] op_b,
  output dsp_elem_pkg::ctrl_s ctrl,
  output logic [51:0] accum_load_value,
  output logic [3:0] ce_lines,
  output logic [3:0] rst_lines,
  output logic [W-1:0] shift_in
);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op_a <= '0;
      op_b <= '0;
      ctrl <= '0;
      accum_load_value <= '0;
      ce_lines <= 4'h0;
      rst_lines <= 4'h0;
      shift_in <= '0;
    end
    else
    begin
      op_a <= a_next;
      op_b <= b_next;
      ctrl <= ctrl_next;
      accum_load_value <= ld_next;
      ce_lines <= ce_next;
      rst_lines <= rst_next;
      shift_in <= sh_next;
    end
  end
endmodule : fabric_model
`default_nettype wire

// ==== test/dsp_mac_addsub_element_tb_top.sv ====
// testbench for the multiply element
`timescale 1ns/1ns
`default_nettype none
module dsp_mac_addsub_element_tb_top;
  localparam logic [6:0] CT [4] = '{7'h00, 7'h20, 7'h40, 7'h20};
  localparam logic [51:0] EX [4] = '{52'h16, 52'h3E, 52'h23, 52'h43};
  logic hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0][17:0] a_s, b_s, a_next, b_next, op_a, op_b;
  dsp_elem_pkg::ctrl_s ctrl_next, ctrl;
  logic [51:0] ld_next, ld, result;
  logic [3:0] ce_next, rst_next, ce_lines, rst_lines;
  logic [17:0] sh;
  logic [17:0] sh_next, sa_o, sb_o;
  int failures, total_checks;
  fabric_model #(.W(18)) fab (.hclk(hclk), .hresetn(hresetn), .a_next(a_next),
    .b_next(b_next), .ctrl_next(ctrl_next), .ld_next(ld_next), .ce_next(ce_next),
    .rst_next(rst_next), .sh_next(sh_next), .op_a(op_a), .op_b(op_b), .ctrl(ctrl),
    .accum_load_value(ld),
    .ce_lines(ce_lines), .rst_lines(rst_lines), .shift_in(sh));
  dsp_mac_addsub_element #(.W(18)) dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .op_a(op_a), .op_b(op_b), .shift_a_in(sh), .shift_b_in(sh),
    .ctrl(ctrl), .accum_load_value(ld), .ce_lines(ce_lines), .rst_lines(rst_lines),
    .result(result), .shift_a_out(sa_o), .shift_b_out(sb_o));
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task chk(input logic [51:0] seen, input logic [51:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    r = hrdata;
    if (n >= 50)
    begin
      failures++;
      stop_test();
    end
  endtask : bus
  task step(input logic [3:0] ce, input logic [3:0] rst, input logic [6:0] c,
            input logic [51:0] v);
    @(posedge hclk);
    a_next <= a_s;
    b_next <= b_s;
    ctrl_next <= c;
    ld_next <= v;
    ce_next <= ce;
    rst_next <= rst;
    @(posedge hclk);
    ce_next <= 4'h0;
    rst_next <= 4'h0;
    repeat (2) @(posedge hclk);
    #1;
  endtask : step
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, a_next, b_next} = '0;
    {ctrl_next, ld_next, ce_next, rst_next, a_s, b_s, failures, total_checks} = '0;
    clk_en = 1'b1;
    hsize = 3'h2;
    sh_next = 18'h2A5A5;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(result, 52'h0);
    bus(1'b0, dsp_elem_pkg::CFG_OFS, 32'h0, q);
    chk(q, 52'h0);
    $display("test reset done");
    step(4'h1, 4'h0, 7'h10, 52'hFFFFFFFFFFFFE);
    chk(result, 52'hFFFFFFFFFFFFE);
    a_s[0] = 18'h3;
    b_s[0] = 18'h1;
    step(4'h1, 4'h0, 7'h00, 52'h0);
    chk(result, 52'h1);
    a_s[0] = 18'h3FFFF;
    b_s[0] = 18'h5;
    step(4'h1, 4'h0, 7'h0C, 52'h0);
    chk(result, 52'hFFFFFFFFFFFFC);
    bus(1'b0, dsp_elem_pkg::RESLO_OFS, 32'h0, q);
    chk(q, 52'hFFFFFFFC);
    bus(1'b0, dsp_elem_pkg::RESHI_OFS, 32'h0, q);
    chk(q, 52'hFFFFF);
    step(4'h1, 4'h0, 7'h00, 52'h0);
    chk(result, 52'h13FFF7);
    chk(sa_o, 18'h2A5A5);
    chk(sb_o, 18'h2A5A5);
    step(4'h0, 4'h1, 7'h00, 52'h0);
    chk(result, 52'h0);
    chk(sa_o, 18'h0);
    $display("test mac done");
    a_s = {18'h2, 18'h3, 18'h4, 18'h7};
    b_s = {18'h2, 18'h3, 18'h5, 18'h6};
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, dsp_elem_pkg::CFG_OFS, (i < 2) ? 32'h1 : 32'h2, q);
      step(4'h1, 4'h0, CT[i], 52'h0);
      chk(result, EX[i]);
    end
    $display("test addsub sum done");
    bus(1'b1, dsp_elem_pkg::CFG_OFS, 32'h8000, q);
    bus(1'b1, dsp_elem_pkg::ROUTE_OFS, 32'h200, q);
    bus(1'b0, dsp_elem_pkg::CFG_OFS, 32'h0, q);
    chk(q, 52'h8000);
    step(4'h1, 4'h0, 7'h10, 52'h123);
    chk(result, 52'h43);
    step(4'h4, 4'h0, 7'h10, 52'h123);
    chk(result, 52'h123);
    @(posedge hclk);
    clk_en <= 1'b0;
    step(4'h4, 4'h0, 7'h10, 52'h7);
    chk(result, 52'h123);
    @(posedge hclk);
    clk_en <= 1'b1;
    bus(1'b0, 32'h20, 32'h0, q);
    chk(q, 52'h0);
    $display("test advanced done");
    bus(1'b1, dsp_elem_pkg::CFG_OFS, 32'h0FE9, q);
    a_s[0] = 18'h9;
    step(4'h1, 4'h0, 7'h0F, 52'h0);
    chk(result, 52'h16);
    step(4'h1, 4'h0, 7'h0F, 52'h0);
    chk(result, 52'h22);
    bus(1'b0, dsp_elem_pkg::STAT_OFS, 32'h0, q);
    chk(q, 52'h60);
    $display("test pipeline done");
    stop_test();
  end
endmodule : dsp_mac_addsub_element_tb_top
`default_nettype wire
